// ---- rtl/gate_spi_pkg.sv ----
`default_nettype none
package gate_spi_pkg;
  // frame layout
  localparam int FRAME_BITS = 16;
  localparam int CMD_BITS = 5;
  localparam int RNW_BIT = 15;
  localparam int ADDR_HI = 14;
  localparam int ADDR_LO = 11;
  localparam int DATA_BITS = 8;
  localparam logic [4:0] CNT_CMD_LAST = 5'h04;
  localparam logic [4:0] CNT_DATA_FIRST = 5'h08;
  localparam logic [4:0] CNT_FULL = 5'h10;
  localparam logic [4:0] CNT_OVER = 5'h11;
  // register addresses
  localparam logic [3:0] ADDR_FAULT_SUMMARY = 4'h0;
  localparam logic [3:0] ADDR_DETAIL = 4'h1;
  localparam logic [3:0] ADDR_MAIN = 4'h2;
  localparam logic [3:0] ADDR_DRIVE_WD = 4'h3;
  localparam logic [3:0] ADDR_OC_MON = 4'h4;
  localparam logic [3:0] ADDR_CHOP_AMP = 4'h5;
  // reset values and write masks
  localparam logic [7:0] MAIN_RST = 8'h18;
  localparam logic [7:0] DRIVE_WD_RST = 8'h07;
  localparam logic [7:0] OC_MON_RST = 8'h70;
  localparam logic [7:0] CHOP_AMP_RST = 8'h01;
  localparam logic [7:0] OC_MON_WMASK = 8'hF3;
  localparam logic [6:0] FAULT_RST = 7'h00;
  localparam logic [3:0] DETAIL_RST = 4'h0;
  // main control fields
  localparam int CLR_BIT = 0;
  localparam int LOCK_HI = 5;
  localparam int LOCK_LO = 3;
  localparam logic [2:0] LOCK_KEY = 3'h6;
  localparam logic [2:0] UNLOCK_KEY = 3'h3;
  // drive/watchdog control fields
  localparam int WD_EN_BIT = 5;
  // fault summary bit positions
  localparam int FLT_ANY = 7;
  localparam int FLT_WD = 6;
  localparam int FLT_GATE = 5;
  localparam int FLT_OC = 4;
  localparam int FLT_SUPPLY = 3;
  localparam int FLT_PUMP = 2;
  localparam int FLT_OVERTEMP_SHUTDOWN_FLAG = 1;
  localparam int FLT_OTW = 0;
  // watchdog timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [6:0] WD_MS_0 = 7'h0A;
  localparam logic [6:0] WD_MS_1 = 7'h14;
  localparam logic [6:0] WD_MS_2 = 7'h32;
  localparam logic [6:0] WD_MS_3 = 7'h64;
  // synchroniser reset levels: select and sleep request idle high
  localparam logic [12:0] PIN_IDLE = 13'h0A00;
endpackage
`default_nettype wire

// ---- rtl/level_sync.sv ----
`timescale 1ns/1ns
`default_nettype none
module level_sync #(
  parameter int W = 1,
  // pin idle levels, so that no false edge follows reset
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // asynchronous levels in, synchronous levels out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  // first stage feeds the second stage only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/watchdog_timer.sv ----
`timescale 1ns/1ns
`default_nettype none
module watchdog_timer
  import gate_spi_pkg::*;
#(
  parameter int MS_CYC = MS_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic enable,
  input wire logic restart,
  input wire logic [1:0] interval,
  // one-cycle pulse on timeout
  output logic expire
);
  logic [31:0] div_r;
  logic ms_tick_r;
  logic [6:0] ms_r;

  function automatic logic [6:0] limit_ms(input logic [1:0] sel);
    case (sel)
      2'h0: limit_ms = WD_MS_0;
      2'h1: limit_ms = WD_MS_1;
      2'h2: limit_ms = WD_MS_2;
      default: limit_ms = WD_MS_3;
    endcase
  endfunction

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= '0;
      ms_tick_r <= 1'b0;
    end else if (!enable || restart) begin
      div_r <= '0;
      ms_tick_r <= 1'b0;
    end else begin
      ms_tick_r <= (div_r == 32'(MS_CYC - 1));
      div_r <= (div_r == 32'(MS_CYC - 1)) ? '0 : div_r + 32'h1;
    end
  end

  // a read of address zero restarts the whole countdown, divider included
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ms_r <= '0;
      expire <= 1'b0;
    end else if (!enable || restart) begin
      ms_r <= '0;
      expire <= 1'b0;
    end else if (ms_tick_r && (ms_r + 7'h1 >= limit_ms(interval))) begin
      ms_r <= '0;
      expire <= 1'b1;
    end else begin
      ms_r <= ms_r + (ms_tick_r ? 7'h1 : 7'h0);
      expire <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/gate_driver_spi_regs.sv ----
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// RULE1: frame is 16 bits: command, spare, data
// RULE2: bit15 read flag, 14-11 address, 7-0 data
// RULE3: read returns current register contents
// RULE4: write returns old register contents
// RULE5: output upper byte zero, lower byte register
// RULE6: master uses idle-low clock, phase one
// RULE7: sample on falling, launch on rising edge
// RULE8: most significant bit first both ways
// RULE9: clock held low around select edges
// RULE10: select high at least 500 ns between frames
// RULE11: deselected: ignore inputs, output released
// RULE12: write with wrong bit count is discarded
// RULE13: master may do dummy read after power-up
// RULE14: wake or lockout exit restores defaults
// RULE15: status read-only reset zero, control read/write
// RULE16: summary bit is OR of bits 6-1
// RULE17: summary bits map the fault sources
// RULE18: detail bits 5,4,1 flagged, others zero; code also flags bit 0
// RULE19: master never writes unmapped addresses
// RULE20: reading address zero restarts watchdog
// RULE21: clear bit clears latched faults
// RULE22: lock key freezes all but main control
// RULE23: fault bits stick until cleared
// RULE24: commit only at select rise after 16 clocks
module gate_driver_spi_regs
  import gate_spi_pkg::*;
#(
  parameter int MS_CYC = MS_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // serial port
  input wire logic sclk,
  input wire logic serial_select_n,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe_n,
  // power state
  input wire logic sleep_request_n,
  input wire logic supply_undervoltage_lockout,
  // fault detectors
  input wire logic hs_gate_fault_det,
  input wire logic ls_gate_fault_det,
  input wire logic hs_overcurrent_det,
  input wire logic ls_overcurrent_det,
  input wire logic supply_uv_det,
  input wire logic pump_uv_det,
  input wire logic overtemp_shutdown_det,
  input wire logic overtemp_warning_det,
  // settings to the driver
  output logic in1_ctrl,
  output logic in2_ctrl,
  output logic [1:0] dead_time,
  output logic watchdog_enable,
  output logic [1:0] watchdog_interval,
  output logic [2:0] drive_current,
  output logic amp_limit,
  output logic [2:0] oc_threshold,
  output logic hs_monitor_off,
  output logic ls_monitor_off,
  output logic [1:0] off_time,
  output logic chop_disable,
  output logic [1:0] vref_scale,
  output logic sample_hold_en,
  output logic [1:0] amp_gain,
  // status
  output logic watchdog_expired_flag
);
  logic sclk_q, cs_n_q, sdi_q, sleep_n_q, lockout_q;
  logic hsg_q, lsg_q, hso_q, lso_q, suv_q, puv_q, ots_q, otw_q;
  logic sclk_prev_r, cs_n_prev_r, sleep_n_prev_r, lockout_prev_r;
  logic sclk_fall, sclk_rise, cs_rise, cs_fall, selected;
  logic [4:0] cnt_r;
  logic [15:0] shift_r;
  logic [7:0] rd_byte_r, rd_mux;
  logic [3:0] rd_addr;
  logic sdo_r, sdo_oe_n_r;
  logic [7:0] main_r, drive_wd_r, oc_mon_r, chop_amp_r;
  logic locked_r;
  logic [6:0] fault_r;
  logic [3:0] detail_r;
  logic frame_ok, do_write, do_read, wr_ok, clear_req, settings_reset;
  logic [3:0] wr_addr;
  logic [7:0] wr_data;
  logic wd_expire;
  level_sync #(.W(13), .RST_VAL(PIN_IDLE)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({sclk, serial_select_n, sdi, sleep_request_n, supply_undervoltage_lockout,
        hs_gate_fault_det, ls_gate_fault_det, hs_overcurrent_det, ls_overcurrent_det,
        supply_uv_det, pump_uv_det, overtemp_shutdown_det, overtemp_warning_det}),
    .q({sclk_q, cs_n_q, sdi_q, sleep_n_q, lockout_q,
        hsg_q, lsg_q, hso_q, lso_q, suv_q, puv_q, ots_q, otw_q})
  );
  ////////////////////////////////////////////////////////////////////////////
  // edge detection on synchronised pins
  // select resets to high so no frame is seen while the pin settles
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_prev_r <= 1'b0;
      cs_n_prev_r <= 1'b1;
      sleep_n_prev_r <= 1'b1;
      lockout_prev_r <= 1'b0;
    end else begin
      sclk_prev_r <= sclk_q;
      cs_n_prev_r <= cs_n_q;
      sleep_n_prev_r <= sleep_n_q;
      lockout_prev_r <= lockout_q;
    end
  end
  assign selected = !cs_n_q && !cs_n_prev_r;
  assign sclk_fall = selected && sclk_prev_r && !sclk_q; // RULE7 RULE11
  assign sclk_rise = selected && !sclk_prev_r && sclk_q; // RULE7 RULE11
  assign cs_rise = cs_n_q && !cs_n_prev_r;
  assign cs_fall = !cs_n_q && cs_n_prev_r;
  assign settings_reset = (sleep_n_q && !sleep_n_prev_r) ||
                          (!lockout_q && lockout_prev_r); // RULE14
  ////////////////////////////////////////////////////////////////////////////
  // input shifter and clock counter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_r <= '0;
      cnt_r <= '0;
    end else if (cs_fall) begin
      cnt_r <= '0;
    end else if (sclk_fall) begin
      shift_r <= {shift_r[FRAME_BITS-2:0], sdi_q}; // RULE8 RULE1
      cnt_r <= (cnt_r == CNT_OVER) ? CNT_OVER : cnt_r + 5'h1;
    end
  end
  // address is complete on the fifth falling edge
  assign rd_addr = {shift_r[CMD_BITS-3:0], sdi_q}; // RULE2
  always_comb begin
    rd_mux = '0;
    case (rd_addr)
      ADDR_FAULT_SUMMARY: rd_mux = {|fault_r[FLT_WD:FLT_OVERTEMP_SHUTDOWN_FLAG], fault_r}; // RULE16
      ADDR_DETAIL: rd_mux = {2'h0, detail_r[3:2], 2'h0, detail_r[1:0]}; // RULE18
      ADDR_MAIN: rd_mux = {main_r[7:6], locked_r ? LOCK_KEY : UNLOCK_KEY, main_r[2:1], 1'b0};
      ADDR_DRIVE_WD: rd_mux = drive_wd_r;
      ADDR_OC_MON: rd_mux = oc_mon_r;
      ADDR_CHOP_AMP: rd_mux = chop_amp_r;
      default: rd_mux = '0;
    endcase
  end
  // snapshot before any commit, so a write returns the old value
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_byte_r <= '0;
    end else if (sclk_fall && cnt_r == CNT_CMD_LAST) begin
      rd_byte_r <= rd_mux; // RULE3 RULE4
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // output line
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sdo_r <= 1'b0;
      sdo_oe_n_r <= 1'b1;
    end else begin
      sdo_oe_n_r <= !selected; // RULE11
      if (!selected) begin
        sdo_r <= 1'b0;
      end else if (sclk_rise) begin
        if (cnt_r >= CNT_DATA_FIRST && cnt_r < CNT_FULL) begin
          sdo_r <= rd_byte_r[~cnt_r[2:0]]; // RULE5 RULE8
        end else begin
          sdo_r <= 1'b0; // RULE5
        end
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // frame decode at select rise
  assign frame_ok = cs_rise && (cnt_r == CNT_FULL); // RULE24 RULE12
  assign do_write = frame_ok && !shift_r[RNW_BIT];
  assign do_read = frame_ok && shift_r[RNW_BIT];
  assign wr_addr = shift_r[ADDR_HI:ADDR_LO];
  assign wr_data = shift_r[DATA_BITS-1:0];
  assign wr_ok = do_write && (wr_addr == ADDR_MAIN || !locked_r); // RULE22
  assign clear_req = do_write && wr_addr == ADDR_MAIN && wr_data[CLR_BIT]; // RULE21
  // main control: never locked, clear bit reads back zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      main_r <= MAIN_RST;
      locked_r <= 1'b0;
    end else if (settings_reset) begin
      main_r <= MAIN_RST; // RULE14
      locked_r <= 1'b0;
    end else if (do_write && wr_addr == ADDR_MAIN) begin
      main_r <= {wr_data[7:6], main_r[LOCK_HI:LOCK_LO], wr_data[2:1], 1'b0};
      if (!locked_r && wr_data[LOCK_HI:LOCK_LO] == LOCK_KEY) begin
        locked_r <= 1'b1; // RULE22
      end else if (locked_r && wr_data[LOCK_HI:LOCK_LO] == UNLOCK_KEY) begin
        locked_r <= 1'b0; // RULE22
      end
    end
  end
  // timeout clears the enable; a same-cycle write of it loses
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      drive_wd_r <= DRIVE_WD_RST;
    end else if (settings_reset) begin
      drive_wd_r <= DRIVE_WD_RST;
    end else if (wd_expire) begin
      drive_wd_r[WD_EN_BIT] <= 1'b0;
    end else if (wr_ok && wr_addr == ADDR_DRIVE_WD) begin
      drive_wd_r <= wr_data; // RULE15
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      oc_mon_r <= OC_MON_RST;
      chop_amp_r <= CHOP_AMP_RST;
    end else if (settings_reset) begin
      oc_mon_r <= OC_MON_RST;
      chop_amp_r <= CHOP_AMP_RST;
    end else if (wr_ok && wr_addr == ADDR_OC_MON) begin
      oc_mon_r <= wr_data & OC_MON_WMASK;
    end else if (wr_ok && wr_addr == ADDR_CHOP_AMP) begin
      chop_amp_r <= wr_data;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // sticky fault flags, a new event beats a clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_r <= FAULT_RST; // RULE15
      detail_r <= DETAIL_RST;
    end else begin
      fault_r <= {wd_expire, hsg_q | lsg_q, hso_q | lso_q, suv_q, puv_q, ots_q, otw_q}
                 | (clear_req ? FAULT_RST : fault_r); // RULE17 RULE23 RULE21
      detail_r <= {hsg_q, lsg_q, hso_q, lso_q}
                  | (clear_req ? DETAIL_RST : detail_r); // RULE18 RULE23
    end
  end
  watchdog_timer #(.MS_CYC(MS_CYC)) u_wd (
    .clk(clk),
    .rst_n(rst_n),
    .enable(drive_wd_r[WD_EN_BIT]),
    .restart(do_read && wr_addr == ADDR_FAULT_SUMMARY), // RULE20
    .interval(drive_wd_r[4:3]),
    .expire(wd_expire)
  );
  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign sdo = sdo_r;
  assign sdo_oe_n = sdo_oe_n_r;
  assign in1_ctrl = main_r[2];
  assign in2_ctrl = main_r[1];
  assign dead_time = drive_wd_r[7:6];
  assign watchdog_enable = drive_wd_r[WD_EN_BIT];
  assign watchdog_interval = drive_wd_r[4:3];
  assign drive_current = drive_wd_r[2:0];
  assign amp_limit = oc_mon_r[7];
  assign oc_threshold = oc_mon_r[6:4];
  assign hs_monitor_off = oc_mon_r[1];
  assign ls_monitor_off = oc_mon_r[0];
  assign off_time = chop_amp_r[7:6];
  assign chop_disable = chop_amp_r[5];
  assign vref_scale = chop_amp_r[4:3];
  assign sample_hold_en = chop_amp_r[2];
  assign amp_gain = chop_amp_r[1:0];
  assign watchdog_expired_flag = fault_r[FLT_WD];
  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_release_when_idle;
    @(posedge clk) disable iff (!rst_n) cs_n_q |=> sdo_oe_n_r && !sdo_r;
  endproperty
  a_release_when_idle: assert property (p_release_when_idle) // RULE11
    else $error("output not released while deselected");
  property p_bad_count_discard;
    @(posedge clk) disable iff (!rst_n)
      (cs_rise && cnt_r != CNT_FULL && !settings_reset && !wd_expire) |=>
      $stable(main_r) && $stable(drive_wd_r) && $stable(oc_mon_r) && $stable(chop_amp_r);
  endproperty
  a_bad_count_discard: assert property (p_bad_count_discard) // RULE12
    else $error("register changed by a bad frame");
  property p_commit_cfg;
    @(posedge clk) disable iff (!rst_n)
      (do_write && wr_addr == ADDR_CHOP_AMP && !locked_r && !settings_reset) |=>
      chop_amp_r == $past(wr_data);
  endproperty
  a_commit_cfg: assert property (p_commit_cfg) // RULE24
    else $error("write data not committed");
  property p_locked_hold;
    @(posedge clk) disable iff (!rst_n)
      (locked_r && do_write && wr_addr == ADDR_OC_MON && !settings_reset) |=> $stable(oc_mon_r);
  endproperty
  a_locked_hold: assert property (p_locked_hold) // RULE22
    else $error("locked register changed");
  property p_sticky;
    @(posedge clk) disable iff (!rst_n) (fault_r[FLT_OC] && !clear_req) |=> fault_r[FLT_OC];
  endproperty
  a_sticky: assert property (p_sticky) // RULE23
    else $error("fault flag dropped without clear");
  // a detector that comes back one cycle after the clear may set the flag again
  property p_clear;
    @(posedge clk) disable iff (!rst_n)
      (clear_req && !hso_q && !lso_q) |=> !fault_r[FLT_OC] ##1
      (!fault_r[FLT_OC] || $past(hso_q) || $past(lso_q));
  endproperty
  a_clear: assert property (p_clear) // RULE21
    else $error("clear did not remove fault flag");
  property p_wake_defaults;
    @(posedge clk) disable iff (!rst_n)
      settings_reset |=> chop_amp_r == CHOP_AMP_RST && oc_mon_r == OC_MON_RST && !locked_r;
  endproperty
  a_wake_defaults: assert property (p_wake_defaults) // RULE14
    else $error("settings not restored on wake");
  property p_first_data_bit;
    @(posedge clk) disable iff (!rst_n)
      (sclk_rise && cnt_r == CNT_DATA_FIRST) |=> sdo_r == rd_byte_r[7];
  endproperty
  a_first_data_bit: assert property (p_first_data_bit) // RULE5
    else $error("data byte not sent msb first");
  property p_upper_zero;
    @(posedge clk) disable iff (!rst_n)
      (sclk_rise && cnt_r < CNT_DATA_FIRST) |=> !sdo_r;
  endproperty
  a_upper_zero: assert property (p_upper_zero) // RULE5
    else $error("upper byte not zero");
  property p_timeout_effect;
    @(posedge clk) disable iff (!rst_n)
      wd_expire |=> !drive_wd_r[WD_EN_BIT] && fault_r[FLT_WD];
  endproperty
  a_timeout_effect: assert property (p_timeout_effect) // RULE20
    else $error("watchdog timeout not handled");
  c_write: cover property (@(posedge clk) disable iff (!rst_n) do_write);
  c_read: cover property (@(posedge clk) disable iff (!rst_n) do_read);
  c_bad_frame: cover property (@(posedge clk) disable iff (!rst_n) cs_rise && cnt_r != CNT_FULL);
  c_timeout: cover property (@(posedge clk) disable iff (!rst_n) wd_expire);
endmodule
`default_nettype wire

// ---- bench/spi_master_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module spi_master_model #(
  parameter int HALF = 10
) (
  // bench clock
  input wire logic clk,
  // serial port
  output logic sclk,
  output logic serial_select_n,
  output logic sdi,
  input wire logic sdo_line
);
  initial begin
    sclk = 1'b0;
    serial_select_n = 1'b1;
    sdi = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // one frame; a count other than 16 makes a deliberately broken frame
  task automatic frame(input logic [15:0] word, input int nclk, output logic [15:0] rd);
    rd = 16'h0000;
    @(negedge clk);
    serial_select_n = 1'b0;
    repeat (HALF) @(negedge clk);
    for (int i = 0; i < nclk; i++) begin
      sclk = 1'b1;
      sdi = (i < 16) ? word[15-i] : 1'b0;
      repeat (HALF) @(negedge clk);
      sclk = 1'b0;
      rd = {rd[14:0], sdo_line};
      repeat (HALF) @(negedge clk);
    end
    serial_select_n = 1'b1;
    // a released data line must not look like it kept its level
    sdi = ~sdi;
    repeat (64) @(negedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // clock and data activity while deselected, slow enough for the sampler
  task automatic idle_noise();
    for (int i = 0; i < 8; i++) begin
      sclk = ~sclk;
      sdi = ~sdi;
      repeat (4) @(negedge clk);
    end
  endtask
endmodule
`default_nettype wire

// ---- bench/testbench.sv ----
`timescale 1ns/1ns
`default_nettype none
module testbench
  import gate_spi_pkg::*;
;
  localparam int MS_SIM = 100;
  logic clk;
  logic rst_n;
  logic sclk;
  logic serial_select_n;
  logic sdi;
  logic sdo;
  logic sdo_oe_n;
  wire logic sdo_line;
  logic sleep_request_n;
  logic supply_undervoltage_lockout;
  logic [7:0] det;
  logic in1_ctrl, in2_ctrl, watchdog_enable, amp_limit, hs_monitor_off, ls_monitor_off;
  logic chop_disable, sample_hold_en, watchdog_expired_flag;
  logic [1:0] dead_time, watchdog_interval, off_time, vref_scale, amp_gain;
  logic [2:0] drive_current, oc_threshold;
  logic [7:0] out3, out4, out5;
  int miscompares;
  int total_checks;
  // expected status per detector, index = det bit
  logic [7:0] sum_exp [0:7] = '{8'h01, 8'h82, 8'h84, 8'h88, 8'h90, 8'h90, 8'hA0, 8'hA0};
  logic [7:0] det_exp [0:7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h02, 8'h10, 8'h20};

  // a released line shows the inverse of sdo, which is held low while deselected, so a late sample is caught
  assign sdo_line = sdo_oe_n ? ~sdo : sdo;
  assign out3 = {dead_time, watchdog_enable, watchdog_interval, drive_current};
  assign out4 = {amp_limit, oc_threshold, 2'b00, hs_monitor_off, ls_monitor_off};
  assign out5 = {off_time, chop_disable, vref_scale, sample_hold_en, amp_gain};
  always #4 clk = ~clk;

  gate_driver_spi_regs #(.MS_CYC(MS_SIM)) i_gate_driver_spi_regs (
    .clk(clk), .rst_n(rst_n), .sclk(sclk), .serial_select_n(serial_select_n), .sdi(sdi),
    .sdo(sdo), .sdo_oe_n(sdo_oe_n), .sleep_request_n(sleep_request_n),
    .supply_undervoltage_lockout(supply_undervoltage_lockout),
    .hs_gate_fault_det(det[7]), .ls_gate_fault_det(det[6]), .hs_overcurrent_det(det[5]),
    .ls_overcurrent_det(det[4]), .supply_uv_det(det[3]), .pump_uv_det(det[2]),
    .overtemp_shutdown_det(det[1]), .overtemp_warning_det(det[0]),
    .in1_ctrl(in1_ctrl), .in2_ctrl(in2_ctrl), .dead_time(dead_time),
    .watchdog_enable(watchdog_enable), .watchdog_interval(watchdog_interval),
    .drive_current(drive_current), .amp_limit(amp_limit), .oc_threshold(oc_threshold),
    .hs_monitor_off(hs_monitor_off), .ls_monitor_off(ls_monitor_off), .off_time(off_time),
    .chop_disable(chop_disable), .vref_scale(vref_scale), .sample_hold_en(sample_hold_en),
    .amp_gain(amp_gain), .watchdog_expired_flag(watchdog_expired_flag)
  );
  spi_master_model i_spi_master_model (
    .clk(clk), .sclk(sclk), .serial_select_n(serial_select_n), .sdi(sdi), .sdo_line(sdo_line)
  );
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check_val(input string name, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic check_flag(input string name, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // reads carry nonzero data so a read mistaken for a write shows up
  task automatic rd(input logic [3:0] a, output logic [15:0] r);
    i_spi_master_model.frame({1'b1, a, 3'b000, 8'hA5}, 16, r);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d, output logic [15:0] r);
    i_spi_master_model.frame({1'b0, a, 3'b101, d}, 16, r);
  endtask
  task automatic expect_reg(input string name, input logic [3:0] a, input logic [7:0] v);
    logic [15:0] r;
    rd(a, r);
    check_val(name, {8'h00, v}, r);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [15:0] r;
    rd(ADDR_MAIN, r);
    expect_reg("summary", ADDR_FAULT_SUMMARY, 8'h00);
    expect_reg("detail", ADDR_DETAIL, 8'h00);
    expect_reg("main", ADDR_MAIN, MAIN_RST);
    expect_reg("drive_wd", ADDR_DRIVE_WD, DRIVE_WD_RST);
    expect_reg("oc_mon", ADDR_OC_MON, OC_MON_RST);
    expect_reg("chop", ADDR_CHOP_AMP, CHOP_AMP_RST);
    expect_reg("unmapped", 4'hA, 8'h00);
    check_val("out3", {8'h00, DRIVE_WD_RST}, {8'h00, out3});
    check_flag("sdo_oe_n", 1'b1, sdo_oe_n);
  endtask
  task automatic t_write();
    logic [15:0] r;
    wr(ADDR_CHOP_AMP, 8'h55, r);
    check_val("old_chop", {8'h00, CHOP_AMP_RST}, r);
    expect_reg("chop", ADDR_CHOP_AMP, 8'h55);
    check_val("out5", 16'h0055, {8'h00, out5});
    wr(ADDR_OC_MON, 8'hFF, r);
    check_val("old_oc", {8'h00, OC_MON_RST}, r);
    expect_reg("oc_mon", ADDR_OC_MON, OC_MON_WMASK);
    check_val("out4", {8'h00, OC_MON_WMASK}, {8'h00, out4});
    wr(ADDR_DRIVE_WD, 8'hDA, r);
    check_val("out3", 16'h00DA, {8'h00, out3});
    wr(ADDR_FAULT_SUMMARY, 8'hFF, r);
    expect_reg("summary_ro", ADDR_FAULT_SUMMARY, 8'h00);
  endtask
  task automatic t_frame_err();
    logic [15:0] r;
    i_spi_master_model.frame({1'b0, ADDR_CHOP_AMP, 3'b000, 8'h33}, 15, r);
    i_spi_master_model.frame({1'b0, ADDR_CHOP_AMP, 3'b000, 8'h33}, 17, r);
    i_spi_master_model.idle_noise();
    check_flag("sdo_oe_n_idle", 1'b1, sdo_oe_n);
    expect_reg("chop_kept", ADDR_CHOP_AMP, 8'h55);
  endtask
  task automatic t_lock();
    logic [15:0] r;
    wr(ADDR_MAIN, 8'h30, r);
    check_val("old_main", {8'h00, MAIN_RST}, r);
    wr(ADDR_CHOP_AMP, 8'h0F, r);
    expect_reg("chop_locked", ADDR_CHOP_AMP, 8'h55);
    wr(ADDR_OC_MON, 8'h00, r);
    expect_reg("oc_locked", ADDR_OC_MON, OC_MON_WMASK);
    wr(ADDR_MAIN, 8'h2E, r);
    expect_reg("main_locked", ADDR_MAIN, 8'h36);
    check_val("in_ctrl", 16'h0003, {14'h0000, in1_ctrl, in2_ctrl});
    wr(ADDR_MAIN, 8'h18, r);
    wr(ADDR_CHOP_AMP, 8'h0F, r);
    expect_reg("chop_unlocked", ADDR_CHOP_AMP, 8'h0F);
  endtask
  task automatic t_faults();
    logic [15:0] r;
    for (int i = 0; i < 8; i++) begin
      det[i] = 1'b1;
      repeat (8) @(negedge clk);
      det[i] = 1'b0;
      repeat (8) @(negedge clk);
      expect_reg("summary", ADDR_FAULT_SUMMARY, sum_exp[i]);
      expect_reg("detail", ADDR_DETAIL, det_exp[i]);
      wr(ADDR_MAIN, 8'h19, r);
      expect_reg("cleared", ADDR_FAULT_SUMMARY, 8'h00);
    end
  endtask
  task automatic t_wake();
    logic [15:0] r;
    det[1] = 1'b1;
    repeat (8) @(negedge clk);
    det[1] = 1'b0;
    wr(ADDR_MAIN, 8'h30, r);
    sleep_request_n = 1'b0;
    repeat (20) @(negedge clk);
    sleep_request_n = 1'b1;
    repeat (20) @(negedge clk);
    expect_reg("main_wake", ADDR_MAIN, MAIN_RST);
    expect_reg("chop_wake", ADDR_CHOP_AMP, CHOP_AMP_RST);
    expect_reg("summary_kept", ADDR_FAULT_SUMMARY, 8'h82);
    wr(ADDR_CHOP_AMP, 8'h77, r);
    supply_undervoltage_lockout = 1'b1;
    repeat (20) @(negedge clk);
    supply_undervoltage_lockout = 1'b0;
    repeat (20) @(negedge clk);
    expect_reg("chop_supply_undervoltage_lockout", ADDR_CHOP_AMP, CHOP_AMP_RST);
    wr(ADDR_MAIN, 8'h19, r);
  endtask
  // interval 00 is 10 units of MS_SIM cycles; a frame takes about 400 cycles
  task automatic t_watchdog();
    logic [15:0] r;
    wr(ADDR_DRIVE_WD, 8'h27, r);
    check_flag("wd_enable", 1'b1, watchdog_enable);
    for (int i = 0; i < 4; i++) begin
      rd(ADDR_FAULT_SUMMARY, r);
    end
    check_flag("wd_kept", 1'b0, watchdog_expired_flag);
    repeat (1100) @(negedge clk);
    check_flag("wd_expired", 1'b1, watchdog_expired_flag);
    check_flag("wd_enable_off", 1'b0, watchdog_enable);
    expect_reg("summary_wd", ADDR_FAULT_SUMMARY, 8'hC0);
    wr(ADDR_MAIN, 8'h19, r);
    check_flag("wd_cleared", 1'b0, watchdog_expired_flag);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    det = 8'h00;
    sleep_request_n = 1'b1;
    supply_undervoltage_lockout = 1'b0;
    miscompares = 0;
    total_checks = 0;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    t_reset();
    t_write();
    t_frame_err();
    t_lock();
    t_faults();
    t_wake();
    t_watchdog();
    print_verdict();
  end
  // whole run is about 30000 cycles
  initial begin
    repeat (80000) @(posedge clk);
    miscompares++;
    print_verdict();
  end
endmodule
`default_nettype wire
